// ---- hdl/irq_pin_wake.sv ----
// Decided for this implementation: the address-and-strobe port.
module irq_pin_wake (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [7:0]         reg_rdata,
	// Event sources
	input  wire logic               frame_sync_pin,
	input  wire logic               sample_ready,
	input  wire logic               buffer_overflow,
	input  wire logic               gyro_drive_ready,
	// Accelerometer samples, in mg
	input  wire logic               accel_valid,
	input  wire logic signed [15:0] accel_x,
	input  wire logic signed [15:0] accel_y,
	input  wire logic signed [15:0] accel_z,
	// Interrupt pin
	output logic                    irq_out,
	output logic                    irq_oe
);

	typedef struct packed {
		logic [7:0]                 thr;
		logic [7:0]                 cfg;
		logic [7:0]                 en;
		logic [7:0]                 status;
		logic                       sync_flag;
		logic                       sync_prev;
		logic                       have_prev;
		logic signed [15:0]         prev_x;
		logic signed [15:0]         prev_y;
		logic signed [15:0]         prev_z;
		irq_wake_pkg::pulse_st_t    pulse;
		logic [8:0]                 pulse_cnt;
		logic                       pin_out;
		logic                       pin_oe;
		logic [7:0]                 rdata;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	logic [7:0]  status_set;
	logic [7:0]  status_clr;
	logic        sync_level;
	logic        sync_set;
	logic        sync_clr;
	logic        new_event;
	logic        pending;
	logic        active;
	logic        drive_lvl;
	logic [16:0] wake_limit;

	// Size of one axis step between samples
	function automatic logic [16:0] abs_step(input logic signed [15:0] a, input logic signed [15:0] b);
		logic [16:0] d;
		d = {a[15], a} - {b[15], b};
		return d[16] ? (~d + 17'h00001) : d;
	endfunction

	// A read clears a flag at its own address, or anywhere when selected
	function automatic logic read_clears(input logic rd, input logic [7:0] a, input logic [7:0] own, input logic anyrd);
		return rd && (a == own || anyrd);
	endfunction

	// Next state: flags, config, pulse timer, pin and read data
	always_comb begin
		nxt_st = st_ff;
		wake_limit = 17'({9'h000, st_ff.thr} * irq_wake_pkg::MG_PER_COUNT);
		status_set = 8'h00;
		if (accel_valid && st_ff.have_prev) begin
			status_set[irq_wake_pkg::ST_WAKE_X] = abs_step(accel_x, st_ff.prev_x) > wake_limit;
			status_set[irq_wake_pkg::ST_WAKE_Y] = abs_step(accel_y, st_ff.prev_y) > wake_limit;
			status_set[irq_wake_pkg::ST_WAKE_Z] = abs_step(accel_z, st_ff.prev_z) > wake_limit;
		end
		// Wake bits only arm when their enable is set
		status_set = status_set & st_ff.en;
		status_set[irq_wake_pkg::ST_OVERFLOW] = buffer_overflow;
		status_set[irq_wake_pkg::ST_GDRIVE] = gyro_drive_ready;
		status_set[irq_wake_pkg::ST_READY] = sample_ready;
		if (accel_valid) begin
			nxt_st.have_prev = 1'b1;
			nxt_st.prev_x = accel_x;
			nxt_st.prev_y = accel_y;
			nxt_st.prev_z = accel_z;
		end
		// Frame-sync edge into the active level
		sync_level = frame_sync_pin ^ st_ff.cfg[irq_wake_pkg::CFG_SYNC_LOW];
		nxt_st.sync_prev = sync_level;
		sync_set = st_ff.cfg[irq_wake_pkg::CFG_SYNC_EN] && sync_level && !st_ff.sync_prev;
		// Read clears; any read clears when selected
		status_clr = 8'h00;
		if (read_clears(reg_rd, reg_addr, irq_wake_pkg::ADDR_IRQ_STAT, st_ff.cfg[irq_wake_pkg::CFG_RD_CLEAR])) begin
			status_clr = 8'hff;
		end
		if (reg_wr && reg_addr == irq_wake_pkg::ADDR_IRQ_CLR) begin
			status_clr = status_clr | reg_wdata;
		end
		sync_clr = read_clears(reg_rd, reg_addr, irq_wake_pkg::ADDR_SYNC_STAT,
			st_ff.cfg[irq_wake_pkg::CFG_RD_CLEAR]);
		// Set wins over a clear in the same cycle
		nxt_st.status = (st_ff.status & ~status_clr) | status_set;
		nxt_st.sync_flag = (st_ff.sync_flag & !sync_clr) | sync_set;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				irq_wake_pkg::ADDR_WAKE_THR: nxt_st.thr = reg_wdata;
				irq_wake_pkg::ADDR_PIN_CFG:  nxt_st.cfg = reg_wdata & irq_wake_pkg::CFG_WR_MASK;
				irq_wake_pkg::ADDR_SRC_EN:   nxt_st.en = reg_wdata & irq_wake_pkg::EN_WR_MASK;
				default: ;
			endcase
		end
		// Combine enabled sources onto one line
		new_event = |(status_set & st_ff.en) || sync_set;
		pending = |(st_ff.status & st_ff.en) || st_ff.sync_flag;
		// Pulse timer; a retrigger mid-pulse does not stretch it
		case (st_ff.pulse)
			irq_wake_pkg::PULSE_IDLE: begin
				if (new_event && !st_ff.cfg[irq_wake_pkg::CFG_LATCH]) begin
					nxt_st.pulse = irq_wake_pkg::PULSE_HIGH;
					nxt_st.pulse_cnt = 9'h000;
				end
			end
			irq_wake_pkg::PULSE_HIGH: begin
				nxt_st.pulse_cnt = st_ff.pulse_cnt + 9'h001;
				if (st_ff.pulse_cnt == irq_wake_pkg::PULSE_LAST) begin
					nxt_st.pulse = irq_wake_pkg::PULSE_IDLE;
					nxt_st.pulse_cnt = 9'h000;
				end
			end
			default: nxt_st.pulse = irq_wake_pkg::PULSE_IDLE;
		endcase
		active = st_ff.cfg[irq_wake_pkg::CFG_LATCH] ? pending : (st_ff.pulse == irq_wake_pkg::PULSE_HIGH);
		// Polarity then drive type
		drive_lvl = active ^ st_ff.cfg[irq_wake_pkg::CFG_LEVEL_LOW];
		if (st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN]) begin
			nxt_st.pin_out = 1'b0;
			nxt_st.pin_oe = !drive_lvl;
		end else begin
			nxt_st.pin_out = drive_lvl;
			nxt_st.pin_oe = 1'b1;
		end
		// Read data valid for one cycle only, pre-clear values
		nxt_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				irq_wake_pkg::ADDR_WAKE_THR:  nxt_st.rdata = st_ff.thr;
				irq_wake_pkg::ADDR_SYNC_STAT: nxt_st.rdata = {st_ff.sync_flag, 7'h00};
				irq_wake_pkg::ADDR_PIN_CFG:   nxt_st.rdata = st_ff.cfg;
				irq_wake_pkg::ADDR_SRC_EN:    nxt_st.rdata = st_ff.en;
				irq_wake_pkg::ADDR_IRQ_STAT:  nxt_st.rdata = st_ff.status;
				default:                      nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// State register; pin is released during reset and driven from the first clock after it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{
				thr:       irq_wake_pkg::RST_THR,
				cfg:       irq_wake_pkg::RST_CFG,
				en:        irq_wake_pkg::RST_EN,
				status:    8'h00,
				sync_flag: 1'b0,
				sync_prev: 1'b0,
				have_prev: 1'b0,
				prev_x:    16'sh0000,
				prev_y:    16'sh0000,
				prev_z:    16'sh0000,
				pulse:     irq_wake_pkg::PULSE_IDLE,
				pulse_cnt: 9'h000,
				pin_out:   1'b0,
				pin_oe:    1'b0,
				rdata:     8'h00
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = st_ff.rdata;
	assign irq_out = st_ff.pin_out;
	assign irq_oe = st_ff.pin_oe;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	thr_write_a: assert property (
		reg_wr && reg_addr == irq_wake_pkg::ADDR_WAKE_THR |=> st_ff.thr == $past(reg_wdata))
		else $error("threshold write lost");
	sync_set_a: assert property (
		sync_set |=> st_ff.sync_flag)
		else $error("sync flag not set");
	sync_clr_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_SYNC_STAT && !sync_set |=> !st_ff.sync_flag)
		else $error("sync flag not cleared on read");
	polarity_a: assert property (
		!st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN] |=> irq_out == ($past(active) ^ $past(st_ff.cfg[7])) && irq_oe)
		else $error("pin polarity wrong");
	open_drain_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN] |=> !irq_out && (irq_oe == !($past(active) ^ $past(st_ff.cfg[7]))))
		else $error("open drain drive wrong");
	pulse_end_a: assert property (
		st_ff.pulse == irq_wake_pkg::PULSE_HIGH && st_ff.pulse_cnt == irq_wake_pkg::PULSE_LAST
		|=> st_ff.pulse == irq_wake_pkg::PULSE_IDLE)
		else $error("pulse too long");
	pulse_start_a: assert property (
		$rose(st_ff.pulse == irq_wake_pkg::PULSE_HIGH) |-> st_ff.pulse_cnt == 9'h000 && !$past(st_ff.cfg[5]))
		else $error("pulse started wrongly");
	latch_hold_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_LATCH] && !st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN] && pending
		|=> irq_oe && irq_out != $past(st_ff.cfg[irq_wake_pkg::CFG_LEVEL_LOW]))
		else $error("latched level dropped");
	any_read_a: assert property (
		reg_rd && st_ff.cfg[irq_wake_pkg::CFG_RD_CLEAR] && status_set == 8'h00 |=> st_ff.status == 8'h00)
		else $error("any read did not clear");
	sync_level_a: assert property (
		sync_set |-> (frame_sync_pin == !st_ff.cfg[irq_wake_pkg::CFG_SYNC_LOW]))
		else $error("sync level wrong");
	sync_gate_a: assert property (
		!st_ff.cfg[irq_wake_pkg::CFG_SYNC_EN] && !st_ff.sync_flag |=> !st_ff.sync_flag)
		else $error("disabled sync raised flag");
	wake_enable_a: assert property (
		$rose(st_ff.status[7]) |-> $past(st_ff.en[7]))
		else $error("wake set while disabled");
	ready_flag_a: assert property (
		sample_ready |=> st_ff.status[irq_wake_pkg::ST_READY])
		else $error("ready flag not set");
	overflow_flag_a: assert property (
		buffer_overflow |=> st_ff.status[irq_wake_pkg::ST_OVERFLOW])
		else $error("overflow flag not set");
	combine_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_LATCH] && !st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN] && |(st_ff.status & st_ff.en)
		|=> irq_oe && irq_out != $past(st_ff.cfg[irq_wake_pkg::CFG_LEVEL_LOW]))
		else $error("enabled flag not on pin");
	wake_detect_a: assert property (
		accel_valid && st_ff.have_prev && st_ff.en[7] && abs_step(accel_x, st_ff.prev_x) > wake_limit
		|=> st_ff.status[irq_wake_pkg::ST_WAKE_X])
		else $error("wake step missed");


	// Read data: one cycle after the strobe, zero otherwise
	rdata_idle_a: assert property (
		!reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data not idle");
	thr_read_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_WAKE_THR
		|=> reg_rdata == $past(st_ff.thr))
		else $error("threshold read wrong");
	sync_read_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_SYNC_STAT
		|=> reg_rdata == {$past(st_ff.sync_flag), 7'h00})
		else $error("sync status read wrong");
	stat_read_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_IRQ_STAT
		|=> reg_rdata == $past(st_ff.status))
		else $error("status read wrong");
	cfg_read_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_PIN_CFG
		|=> reg_rdata == $past(st_ff.cfg))
		else $error("config read wrong");
	en_read_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_SRC_EN
		|=> reg_rdata == $past(st_ff.en))
		else $error("enable read wrong");

	// Writes land with reserved bits forced to zero
	cfg_write_a: assert property (
		reg_wr && reg_addr == irq_wake_pkg::ADDR_PIN_CFG
		|=> st_ff.cfg == ($past(reg_wdata) & irq_wake_pkg::CFG_WR_MASK))
		else $error("config write lost");
	en_write_a: assert property (
		reg_wr && reg_addr == irq_wake_pkg::ADDR_SRC_EN
		|=> st_ff.en == ($past(reg_wdata) & irq_wake_pkg::EN_WR_MASK))
		else $error("enable write lost");

	// Flags stay until a clearing access
	stat_read_clr_a: assert property (
		reg_rd && reg_addr == irq_wake_pkg::ADDR_IRQ_STAT && status_set == 8'h00
		|=> st_ff.status == 8'h00)
		else $error("status read did not clear");
	sync_any_read_a: assert property (
		reg_rd && st_ff.cfg[irq_wake_pkg::CFG_RD_CLEAR] && !sync_set
		|=> !st_ff.sync_flag)
		else $error("any read left sync flag");
	clear_reg_a: assert property (
		reg_wr && reg_addr == irq_wake_pkg::ADDR_IRQ_CLR && status_set == 8'h00
		|=> (st_ff.status & $past(reg_wdata)) == 8'h00)
		else $error("clear register ignored");
	stat_hold_a: assert property (
		!reg_rd && !reg_wr && st_ff.status[irq_wake_pkg::ST_OVERFLOW]
		|=> st_ff.status[irq_wake_pkg::ST_OVERFLOW])
		else $error("overflow flag dropped");
	sync_hold_a: assert property (
		!reg_rd && st_ff.sync_flag
		|=> st_ff.sync_flag)
		else $error("sync flag dropped");
	reserved_zero_a: assert property (
		st_ff.status[3] == 1'b0
		&& st_ff.status[1] == 1'b0)
		else $error("reserved status bit set");

	// Pulse timer walks its full count
	pulse_count_a: assert property (
		st_ff.pulse == irq_wake_pkg::PULSE_HIGH && st_ff.pulse_cnt != irq_wake_pkg::PULSE_LAST
		|=> st_ff.pulse == irq_wake_pkg::PULSE_HIGH && st_ff.pulse_cnt == $past(st_ff.pulse_cnt) + 9'h001)
		else $error("pulse cut short");
	idle_count_a: assert property (
		st_ff.pulse == irq_wake_pkg::PULSE_IDLE
		|-> st_ff.pulse_cnt == 9'h000)
		else $error("pulse counter not parked");
	pulse_trigger_a: assert property (
		st_ff.pulse == irq_wake_pkg::PULSE_IDLE && !st_ff.cfg[irq_wake_pkg::CFG_LATCH] && new_event
		|=> st_ff.pulse == irq_wake_pkg::PULSE_HIGH)
		else $error("pulse not started");

	// Frame-sync edge detection
	sync_edge_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_SYNC_EN] && sync_level && !st_ff.sync_prev
		|=> st_ff.sync_flag)
		else $error("sync edge missed");
	sync_low_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_SYNC_EN] && st_ff.cfg[irq_wake_pkg::CFG_SYNC_LOW] && !frame_sync_pin && !st_ff.sync_prev
		|=> st_ff.sync_flag)
		else $error("low sync edge missed");

	// Wake detection on the other axes, the x-axis gate, and the idle latched pin
	wake_y_a: assert property (
		accel_valid && st_ff.have_prev && st_ff.en[6] && abs_step(accel_y, st_ff.prev_y) > wake_limit
		|=> st_ff.status[irq_wake_pkg::ST_WAKE_Y])
		else $error("wake step missed on y");
	wake_z_a: assert property (
		accel_valid && st_ff.have_prev && st_ff.en[5] && abs_step(accel_z, st_ff.prev_z) > wake_limit
		|=> st_ff.status[irq_wake_pkg::ST_WAKE_Z])
		else $error("wake step missed on z");
	wake_off_a: assert property (
		!st_ff.en[irq_wake_pkg::ST_WAKE_X] && !st_ff.status[irq_wake_pkg::ST_WAKE_X]
		|=> !st_ff.status[irq_wake_pkg::ST_WAKE_X])
		else $error("disarmed wake flag set");
	idle_pin_a: assert property (
		st_ff.cfg[irq_wake_pkg::CFG_LATCH] && !st_ff.cfg[irq_wake_pkg::CFG_OPEN_DRAIN] && !pending
		|=> irq_out == $past(st_ff.cfg[irq_wake_pkg::CFG_LEVEL_LOW]))
		else $error("pin active with nothing pending");

	pulse_seen_c: cover property ($rose(st_ff.pulse == irq_wake_pkg::PULSE_HIGH));
	sync_event_c: cover property (sync_set ##[1:20] sync_clr);
	wake_event_c: cover property ($rose(st_ff.status[irq_wake_pkg::ST_WAKE_Y]));
	set_clear_c:  cover property (status_set[0] && status_clr[0]);
	latch_pin_c:  cover property (st_ff.cfg[irq_wake_pkg::CFG_LATCH] && pending);

endmodule

// ---- hdl/irq_wake_pkg.sv ----
package irq_wake_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_WAKE_THR  = 8'h1f;
	localparam logic [7:0] ADDR_SYNC_STAT = 8'h36;
	localparam logic [7:0] ADDR_PIN_CFG   = 8'h37;
	localparam logic [7:0] ADDR_SRC_EN    = 8'h38;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h3a;
	localparam logic [7:0] ADDR_IRQ_CLR   = 8'h50;

	// Pin configuration fields
	localparam int CFG_LEVEL_LOW  = 7;
	localparam int CFG_OPEN_DRAIN = 6;
	localparam int CFG_LATCH      = 5;
	localparam int CFG_RD_CLEAR   = 4;
	localparam int CFG_SYNC_LOW   = 3;
	localparam int CFG_SYNC_EN    = 2;

	// Status and enable fields, same layout
	localparam int SYNC_FLAG_BIT = 7;
	localparam int ST_WAKE_X     = 7;
	localparam int ST_WAKE_Y     = 6;
	localparam int ST_WAKE_Z     = 5;
	localparam int ST_OVERFLOW   = 4;
	localparam int ST_GDRIVE     = 2;
	localparam int ST_READY      = 0;

	// Writable bits; reserved bits read zero
	localparam logic [7:0] CFG_WR_MASK = 8'hfc;
	localparam logic [7:0] EN_WR_MASK  = 8'hf5;

	// Reset values
	localparam logic [7:0] RST_THR = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_EN  = 8'h00;

	// Wake threshold resolution
	localparam int MG_PER_COUNT = 4;

	// Pulse width in pulse mode
	localparam int PULSE_US          = 50;
	localparam int CLK_KHZ           = 10000;
	localparam int PULSE_CYCLES      = (PULSE_US * CLK_KHZ) / 1000;
	localparam logic [8:0] PULSE_LAST = 9'(PULSE_CYCLES - 1);

	typedef enum logic [0:0] {
		PULSE_IDLE,
		PULSE_HIGH
	} pulse_st_t;

endpackage

// ---- tb/host_irq_model.sv ----
module host_irq_model (
	// Clock
	input  wire logic        ref_clk,
	// Interrupt pin, seen from the host
	input  wire logic        irq_out,
	input  wire logic        irq_oe,
	input  wire logic        active_low,
	// What the host makes of the line
	output logic             pin_active,
	output logic      [15:0] run_len
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        pin_level;
	logic [15:0] cnt;

	// Pull-up on the line, so a released pin reads high
	assign pin_level  = irq_oe ? irq_out : 1'b1;
	assign pin_active = pin_level ^ active_low;

	// Length of the last finished active stretch, for pulse width
	initial begin
		cnt     = 16'h0000;
		run_len = 16'h0000;
	end
	always @(posedge ref_clk) begin
		if (pin_active) begin
			cnt <= cnt + 16'h0001;
		end else if (cnt != 16'h0000) begin
			run_len <= cnt;
			cnt     <= 16'h0000;
		end
	end
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic               ref_clk, rst_n, reg_wr, reg_rd, frame_sync_pin, sample_ready;
	logic               buffer_overflow, gyro_drive_ready, accel_valid, irq_out, irq_oe, pin_active;
	logic [7:0]         reg_addr, reg_wdata, reg_rdata, cfg, d, v, thr;
	logic signed [15:0] accel_x, accel_y, accel_z;
	logic [15:0]        run_len;
	logic [31:0]        seed;
	int                 err_count, comparisons, cycles;

	irq_pin_wake u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync_pin(frame_sync_pin),
		.sample_ready(sample_ready), .buffer_overflow(buffer_overflow), .gyro_drive_ready(gyro_drive_ready),
		.accel_valid(accel_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
		.irq_out(irq_out), .irq_oe(irq_oe));
	host_irq_model u_host (.ref_clk(ref_clk), .irq_out(irq_out), .irq_oe(irq_oe), .active_low(cfg[7]),
		.pin_active(pin_active), .run_len(run_len));

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// Drive enable expected for a given activity and pin mode
	function automatic logic exp_oe(input logic act, input logic [7:0] c);
		return c[6] ? ~(act ^ c[7]) : 1'b1;
	endfunction

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= x;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(n, {8'h00, e}, {8'h00, reg_rdata});
	endtask

	task automatic ev(input logic [2:0] m);
		@(posedge ref_clk);
		{gyro_drive_ready, buffer_overflow, sample_ready} <= m;
		@(posedge ref_clk);
		{gyro_drive_ready, buffer_overflow, sample_ready} <= 3'b000;
	endtask

	task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
		@(posedge ref_clk);
		{accel_x, accel_y, accel_z, accel_valid} <= {x, y, z, 1'b1};
		@(posedge ref_clk);
		accel_valid <= 1'b0;
	endtask

	// Pin follows its cause two edges on; look once it settled
	task automatic pchk(input logic act);
		@(posedge ref_clk);
		#1 chk("pin", {15'h0000, act}, {15'h0000, pin_active});
		chk("oe", {15'h0000, exp_oe(act, cfg)}, {15'h0000, irq_oe});
	endtask

	// Guards against a hang; the run needs about 800 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		{rst_n, reg_wr, reg_rd, frame_sync_pin, sample_ready, buffer_overflow} = 6'h00;
		{gyro_drive_ready, accel_valid, reg_addr, reg_wdata, cfg} = 26'h0000000;
		{accel_x, accel_y, accel_z} = 48'h000000000000;
		seed = 32'd33800;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Reset values, then two unmapped places
		foreach (d[i]) rchk("zero", 8'({8'h1f, 8'h36, 8'h37, 8'h38, 8'h3a, 8'h50, 8'h20, 8'h00} >> (i * 8)), 8'h00);
		thr = xs();
		wr(8'h1f, thr);
		rchk("thr", 8'h1f, thr);
		v = xs() & 8'hf3;
		wr(8'h37, v);
		rchk("cfg", 8'h37, v & irq_wake_pkg::CFG_WR_MASK);
		v = xs();
		wr(8'h38, v);
		rchk("en", 8'h38, v & irq_wake_pkg::EN_WR_MASK);
		wr(8'h38, 8'h01);
		// Every polarity and drive mode, latched
		for (int m = 0; m < 4; m++) begin
			cfg = {m[1:0], 6'h20};
			wr(8'h37, cfg);
			pchk(1'b0);
			ev(3'b001);
			pchk(1'b1);
			rchk("stat", 8'h3a, 8'h01);
			pchk(1'b0);
		end
		// Masked source, then clear register
		wr(8'h38, 8'h00);
		ev(3'b001);
		pchk(1'b0);
		rchk("stat", 8'h3a, 8'h01);
		wr(8'h38, 8'h14);
		ev(3'b110);
		pchk(1'b1);
		wr(8'h50, 8'h14);
		pchk(1'b0);
		rchk("stat", 8'h3a, 8'h00);
		// Pulse mode
		cfg = 8'h00;
		wr(8'h37, cfg);
		wr(8'h38, 8'h01);
		ev(3'b001);
		repeat (600) @(posedge ref_clk);
		chk("pulse", 16'(irq_wake_pkg::PULSE_CYCLES), run_len);
		rchk("stat", 8'h3a, 8'h01);
		// Clear on any read, both settings
		for (int m = 0; m < 2; m++) begin
			cfg = {3'h1, m[0], 4'h0};
			wr(8'h37, cfg);
			ev(3'b001);
			rchk("thr", 8'h1f, thr);
			pchk(~m[0]);
			rchk("stat", 8'h3a, {7'h00, ~m[0]});
		end
		// Frame sync, each level and enable
		for (int m = 0; m < 4; m++) begin
			wr(8'h37, {4'h2, m[1], 3'h0});
			frame_sync_pin <= m[1];
			rchk("sflush", 8'h00, 8'h00);
			rchk("sflush", 8'h36, 8'h00);
			cfg = {4'h2, m[1], m[0], 2'h0};
			wr(8'h37, cfg);
			frame_sync_pin <= ~m[1];
			repeat (2) @(posedge ref_clk);
			rchk("sync", 8'h36, {m[0], 7'h00});
			rchk("sync", 8'h36, 8'h00);
		end
		// Wake on motion just over and at threshold
		wr(8'h38, 8'he0);
		smp(16'sh0000, 16'sh0000, 16'sh0000);
		smp($signed({6'h00, thr, 2'b01}), $signed({6'h00, thr, 2'b00}), -$signed({6'h00, thr, 2'b01}));
		repeat (2) @(posedge ref_clk);
		rchk("wake", 8'h3a, 8'ha0);
		wr(8'h38, 8'h00);
		smp(16'sh0000, 16'sh0000, 16'sh0000);
		repeat (2) @(posedge ref_clk);
		rchk("wake", 8'h3a, 8'h00);
		tally_and_finish();
	end
endmodule
